// ### rtl/rslc_lamp_ctrl.sv
// rslc_lamp_ctrl: front-panel status lamp controller with apb registers.
// assumes status struct comes from logic on clk; battery and wireless pins are asynchronous.
//
// Overview of operation
// - power lamp steady while powered and battery not low
// - low battery blinks power lamp twenty minutes, then automatic shutdown
// - satellite lamp steady once solid lock reported
// - satellite lamp blinks while no solid lock
// - position lamp steady only with differential, good residual and 3D fix
// - residual limit resets to 10.0 m and is host writable
// - differential but residual at or over limit blinks position lamp
// - precision over threshold forces 2D and blinks; threshold 10.5, writable
// - correction lamp steady when locked under 150 or external data good
// - locked but error rate 150 to 499 blinks correction lamp
// - wireless lamp on when connected; off or blink by build option
// - error rate 500 or more counts as no lock
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
module rslc_lamp_ctrl #(
  parameter logic [39:0] LOW_BATT_CYCLES = 40'(rslc_pkg::LOW_BATT_CYCLES),
  parameter logic [31:0] BLINK_HALF_CYCLES = 32'(rslc_pkg::BLINK_HALF_CYCLES),
  parameter bit WL_BLINK_IDLE = 1'b0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire rslc_pkg::rslc_apb_req_type apb_req,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire rslc_pkg::rslc_status_type status,
  input wire logic batt_low_pin,
  input wire logic wireless_conn_pin,
  output logic power_indicator,
  output logic sat_lock_indicator,
  output logic correction_lock_indicator_position_indicator,
  output logic correction_lock_indicator,
  output logic wireless_indicator,
  output logic force_2d,
  output logic auto_shutdown,
  output logic irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic batt_s1_reg;
  logic batt_s2_reg;
  logic wl_s1_reg;
  logic wl_s2_reg;
  logic blink_phase;
  rslc_pkg::rslc_pw_type pw_state_reg;
  rslc_pkg::rslc_pw_type pw_state_next;
  logic [39:0] lowbat_cnt_reg;
  logic [39:0] lowbat_cnt_next;
  logic [15:0] res_limit_reg;
  logic [15:0] res_limit_next;
  logic [15:0] pdop_thr_reg;
  logic [15:0] pdop_thr_next;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_stat_next;
  logic [3:0] irq_mask_reg;
  logic [3:0] irq_mask_next;
  logic [3:0] irq_event;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic [4:0] lamp_reg;
  logic [4:0] lamp_next;
  logic force_2d_reg;
  logic force_2d_next;
  logic sat_d_reg;
  logic corr_d_reg;
  logic corr_locked_eff;
  logic corr_good;
  logic pdop_high;
  logic correction_lock_indicator_good;
  logic wr_en;
  logic addr_ok;
  logic [31:0] rd_word;
  rslc_pkg::rslc_lamp_type mode [rslc_pkg::NUM_LAMPS];

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // pins from outside the clock domain pass two flops before any use
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      batt_s1_reg <= 1'b0;
      batt_s2_reg <= 1'b0;
      wl_s1_reg <= 1'b0;
      wl_s2_reg <= 1'b0;
    end else begin
      batt_s1_reg <= batt_low_pin;
      batt_s2_reg <= batt_s1_reg;
      wl_s1_reg <= wireless_conn_pin;
      wl_s2_reg <= wl_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // shared blink source
  // ----------------------------------------------------------------
  rslc_blink_div #(
    .HALF_CYCLES(BLINK_HALF_CYCLES)
  ) u_blink (
    .clk(clk),
    .rst_b(rst_b),
    .blink_phase(blink_phase)
  );

  // ----------------------------------------------------------------
  // power and low battery sequencer
  // ----------------------------------------------------------------
  // battery recovery (charger plugged in) cancels the countdown
  always_comb begin
    pw_state_next = pw_state_reg;
    lowbat_cnt_next = lowbat_cnt_reg;
    case (pw_state_reg)
      rslc_pkg::PW_NORMAL: begin
        lowbat_cnt_next = 40'h0;
        if (batt_s2_reg) begin
          pw_state_next = rslc_pkg::PW_LOWBAT;
        end
      end
      rslc_pkg::PW_LOWBAT: begin
        if (!batt_s2_reg) begin
          pw_state_next = rslc_pkg::PW_NORMAL;
        end else if (lowbat_cnt_reg >= LOW_BATT_CYCLES - 40'h1) begin
          pw_state_next = rslc_pkg::PW_SHUTDOWN;
        end else begin
          lowbat_cnt_next = lowbat_cnt_reg + 40'h1;
        end
      end
      rslc_pkg::PW_SHUTDOWN: begin
        pw_state_next = rslc_pkg::PW_SHUTDOWN;  // held until reset
      end
      default: begin
        pw_state_next = rslc_pkg::PW_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pw_state_reg <= rslc_pkg::PW_NORMAL;
      lowbat_cnt_reg <= 40'h0;
    end else begin
      pw_state_reg <= pw_state_next;
      lowbat_cnt_reg <= lowbat_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // status decode
  // ----------------------------------------------------------------
  assign corr_locked_eff = status.corr_locked && (status.ber < rslc_pkg::BER_NO_LOCK);
  assign corr_good = (corr_locked_eff && (status.ber < rslc_pkg::BER_MARGINAL))
                     || status.ext_corr_ok;
  assign pdop_high = status.pdop_x10 > pdop_thr_reg;
  assign correction_lock_indicator_good = status.correction_lock_indicator_solution && (status.residual_dm < res_limit_reg)
                     && status.fix_3d && !pdop_high;

  // lamp modes; shutdown darkens the whole panel
  always_comb begin
    for (int i = 0; i < rslc_pkg::NUM_LAMPS; i++) begin
      mode[i] = rslc_pkg::LAMP_OFF;
    end
    if (pw_state_reg != rslc_pkg::PW_SHUTDOWN) begin
      if (pw_state_reg == rslc_pkg::PW_LOWBAT) begin
        mode[rslc_pkg::LAMP_POWER] = rslc_pkg::LAMP_BLINK;
      end else begin
        mode[rslc_pkg::LAMP_POWER] = rslc_pkg::LAMP_ON;
      end
      if (status.sat_lock) begin
        mode[rslc_pkg::LAMP_SAT] = rslc_pkg::LAMP_ON;
      end else begin
        mode[rslc_pkg::LAMP_SAT] = rslc_pkg::LAMP_BLINK;
      end
      if (correction_lock_indicator_good) begin
        mode[rslc_pkg::LAMP_DIFFPOS] = rslc_pkg::LAMP_ON;
      end else if (status.correction_lock_indicator_solution) begin
        mode[rslc_pkg::LAMP_DIFFPOS] = rslc_pkg::LAMP_BLINK;
      end
      if (corr_good) begin
        mode[rslc_pkg::LAMP_CORR] = rslc_pkg::LAMP_ON;
      end else if (corr_locked_eff) begin
        mode[rslc_pkg::LAMP_CORR] = rslc_pkg::LAMP_BLINK;
      end
      if (wl_s2_reg) begin
        mode[rslc_pkg::LAMP_WIRELESS] = rslc_pkg::LAMP_ON;
      end else if (WL_BLINK_IDLE) begin
        mode[rslc_pkg::LAMP_WIRELESS] = rslc_pkg::LAMP_BLINK;
      end
    end
  end

  // ----------------------------------------------------------------
  // registered lamp drive
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < rslc_pkg::NUM_LAMPS; g++) begin : g_lamp
      assign lamp_next[g] = (mode[g] == rslc_pkg::LAMP_ON)
                            || ((mode[g] == rslc_pkg::LAMP_BLINK) && blink_phase);
    end
  endgenerate

  assign force_2d_next = pdop_high;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lamp_reg <= 5'h00;
      force_2d_reg <= 1'b0;
      sat_d_reg <= 1'b0;
      corr_d_reg <= 1'b0;
    end else begin
      lamp_reg <= lamp_next;
      force_2d_reg <= force_2d_next;
      sat_d_reg <= status.sat_lock;
      corr_d_reg <= corr_locked_eff;
    end
  end

  // ----------------------------------------------------------------
  // apb slave and registers
  // ----------------------------------------------------------------
  // zero wait states: read data is captured in the setup cycle
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite && addr_ok;

  always_comb begin
    addr_ok = 1'b1;
    rd_word = 32'h0000_0000;
    if (apb_req.paddr == rslc_pkg::ADDR_RESIDUAL_LIMIT_COMMAND) begin
      rd_word[15:0] = res_limit_reg;
    end else if (apb_req.paddr == rslc_pkg::ADDR_PRECISION_THRESHOLD_COMMAND) begin
      rd_word[15:0] = pdop_thr_reg;
    end else if (apb_req.paddr == rslc_pkg::ADDR_LAMP_STATE) begin
      rd_word[4:0] = lamp_reg;
      rd_word[rslc_pkg::STATE_FORCE_2D] = force_2d_reg;
      rd_word[rslc_pkg::STATE_SHUTDOWN] = (pw_state_reg == rslc_pkg::PW_SHUTDOWN);
      rd_word[rslc_pkg::STATE_PW_LSB +: 2] = pw_state_reg;
    end else if (apb_req.paddr == rslc_pkg::ADDR_IRQ_STAT) begin
      rd_word[3:0] = irq_stat_reg;
    end else if (apb_req.paddr == rslc_pkg::ADDR_IRQ_MASK) begin
      rd_word[3:0] = irq_mask_reg;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // events for the sticky status bits
  assign irq_event[rslc_pkg::IRQ_LOW_BATT] = (pw_state_reg == rslc_pkg::PW_NORMAL)
                                             && (pw_state_next == rslc_pkg::PW_LOWBAT);
  assign irq_event[rslc_pkg::IRQ_SHUTDOWN] = (pw_state_reg == rslc_pkg::PW_LOWBAT)
                                             && (pw_state_next == rslc_pkg::PW_SHUTDOWN);
  assign irq_event[rslc_pkg::IRQ_SAT_LOCK] = status.sat_lock && !sat_d_reg;
  assign irq_event[rslc_pkg::IRQ_CORR_LOST] = corr_d_reg && !corr_locked_eff;

  // register next values; an event in the clearing cycle still sets its bit
  always_comb begin
    res_limit_next = res_limit_reg;
    pdop_thr_next = pdop_thr_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    prdata_next = prdata_reg;
    if (apb_req.psel && !apb_req.penable) begin
      prdata_next = rd_word;
    end
    if (wr_en && apb_req.paddr == rslc_pkg::ADDR_RESIDUAL_LIMIT_COMMAND) begin
      res_limit_next = apb_req.pwdata[15:0];
    end
    if (wr_en && apb_req.paddr == rslc_pkg::ADDR_PRECISION_THRESHOLD_COMMAND) begin
      pdop_thr_next = apb_req.pwdata[15:0];
    end
    if (wr_en && apb_req.paddr == rslc_pkg::ADDR_IRQ_MASK) begin
      irq_mask_next = apb_req.pwdata[3:0];
    end
    if (wr_en && apb_req.paddr == rslc_pkg::ADDR_IRQ_STAT) begin
      irq_stat_next = irq_stat_reg & ~apb_req.pwdata[3:0];
    end
    irq_stat_next = irq_stat_next | irq_event;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      res_limit_reg <= rslc_pkg::RES_LIMIT_RST;
      pdop_thr_reg <= rslc_pkg::PDOP_THR_RST;
      irq_mask_reg <= rslc_pkg::IRQ_MASK_RST;
      irq_stat_reg <= 4'h0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      res_limit_reg <= res_limit_next;
      pdop_thr_reg <= pdop_thr_next;
      irq_mask_reg <= irq_mask_next;
      irq_stat_reg <= irq_stat_next;
      prdata_reg <= prdata_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = apb_req.psel && apb_req.penable && !addr_ok;
  assign prdata = prdata_reg;
  assign power_indicator = lamp_reg[rslc_pkg::LAMP_POWER];
  assign sat_lock_indicator = lamp_reg[rslc_pkg::LAMP_SAT];
  assign correction_lock_indicator_position_indicator = lamp_reg[rslc_pkg::LAMP_DIFFPOS];
  assign correction_lock_indicator = lamp_reg[rslc_pkg::LAMP_CORR];
  assign wireless_indicator = lamp_reg[rslc_pkg::LAMP_WIRELESS];
  assign force_2d = force_2d_reg;
  assign auto_shutdown = (pw_state_reg == rslc_pkg::PW_SHUTDOWN);
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_running;
    pw_state_reg != rslc_pkg::PW_SHUTDOWN;
  endsequence

  sequence s_lowbat_end;
    pw_state_reg == rslc_pkg::PW_LOWBAT && batt_s2_reg
    && lowbat_cnt_reg == LOW_BATT_CYCLES - 40'h1;
  endsequence

  a_power_steady: assert property (pw_state_reg == rslc_pkg::PW_NORMAL |=> power_indicator)
    else $error("power lamp not steady");
  a_lowbat_shut: assert property (s_lowbat_end |=> auto_shutdown ##1 !power_indicator)
    else $error("shutdown not taken at end of countdown");
  a_lowbat_blink: assert property (pw_state_reg == rslc_pkg::PW_LOWBAT
    |=> power_indicator == $past(blink_phase))
    else $error("power lamp not blinking on low battery");
  a_sat_lamp: assert property (s_running |=> sat_lock_indicator
    == ($past(status.sat_lock) || $past(blink_phase)))
    else $error("satellite lamp wrong");
  a_diffpos_good: assert property (s_running and correction_lock_indicator_good |=> correction_lock_indicator_position_indicator)
    else $error("position lamp not steady");
  a_diffpos_blink: assert property (s_running and (status.correction_lock_indicator_solution && !correction_lock_indicator_good)
    |=> correction_lock_indicator_position_indicator == $past(blink_phase))
    else $error("position lamp not blinking");
  a_force_2d: assert property (status.pdop_x10 > pdop_thr_reg |=> force_2d)
    else $error("2D fallback missing");
  a_corr_marginal: assert property (s_running and (corr_locked_eff && !corr_good)
    |=> correction_lock_indicator == $past(blink_phase))
    else $error("correction lamp not blinking");
  a_corr_nolock: assert property ((status.ber >= rslc_pkg::BER_NO_LOCK && !status.ext_corr_ok)
    |=> !correction_lock_indicator)
    else $error("correction lamp lit without lock");
  a_wireless_on: assert property (s_running and wl_s2_reg |=> wireless_indicator)
    else $error("wireless lamp not lit");
  a_reset_defaults: assert property (disable iff (1'b0) !rst_b |=> lamp_reg == 5'h00
    && res_limit_reg == rslc_pkg::RES_LIMIT_RST && pdop_thr_reg == rslc_pkg::PDOP_THR_RST)
    else $error("reset state wrong");

endmodule : rslc_lamp_ctrl

// ### pkg/rslc_pkg.sv
// rslc_pkg: constants, register map and carrier types of the status lamp controller.
// assumes a single 125 MHz clock shared by the bus and the status sources.
package rslc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the apb bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RESIDUAL_LIMIT_COMMAND = 8'h00;
  localparam logic [7:0] ADDR_PRECISION_THRESHOLD_COMMAND = 8'h04;
  localparam logic [7:0] ADDR_LAMP_STATE = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

  // ----------------------------------------------------------------
  // reset values and thresholds
  // ----------------------------------------------------------------
  localparam logic [15:0] RES_LIMIT_RST = 16'h0064;  // 10.0 m in decimetres
  localparam logic [15:0] PDOP_THR_RST = 16'h0069;   // 10.5 in tenths
  localparam logic [15:0] BER_MARGINAL = 16'h0096;   // 150
  localparam logic [15:0] BER_NO_LOCK = 16'h01F4;    // 500
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int NUM_LAMPS = 5;
  localparam int LAMP_POWER = 0;
  localparam int LAMP_SAT = 1;
  localparam int LAMP_DIFFPOS = 2;
  localparam int LAMP_CORR = 3;
  localparam int LAMP_WIRELESS = 4;
  localparam int STATE_FORCE_2D = 5;
  localparam int STATE_SHUTDOWN = 6;
  localparam int STATE_PW_LSB = 8;
  localparam int IRQ_W = 4;
  localparam int IRQ_LOW_BATT = 0;
  localparam int IRQ_SHUTDOWN = 1;
  localparam int IRQ_SAT_LOCK = 2;
  localparam int IRQ_CORR_LOST = 3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ = 64'h0773_5940;       // 125 MHz
  localparam longint unsigned LOW_BATT_MIN = 64'h14;        // 20 minutes
  localparam longint unsigned LOW_BATT_CYCLES = LOW_BATT_MIN * 64'h3C * CLK_HZ;
  localparam longint unsigned BLINK_HALF_MS = 64'h1F4;      // 500 ms per phase
  localparam longint unsigned BLINK_HALF_CYCLES = BLINK_HALF_MS * CLK_HZ / 64'h3E8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LAMP_OFF = 2'b00,
    LAMP_ON = 2'b01,
    LAMP_BLINK = 2'b10
  } rslc_lamp_type;

  typedef enum logic [1:0] {
    PW_NORMAL = 2'b00,
    PW_LOWBAT = 2'b01,
    PW_SHUTDOWN = 2'b10
  } rslc_pw_type;

  typedef struct packed {
    logic sat_lock;
    logic correction_lock_indicator_solution;
    logic fix_3d;
    logic corr_locked;
    logic ext_corr_ok;
    logic [15:0] residual_dm;
    logic [15:0] pdop_x10;
    logic [15:0] ber;
  } rslc_status_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rslc_apb_req_type;

endpackage : rslc_pkg

// ### rtl/rslc_blink_div.sv
// rslc_blink_div: shared blink phase generator for all lamps.
// assumes clk and a synchronous active-low reset.
`timescale 1ns/1ns
module rslc_blink_div #(
  parameter logic [31:0] HALF_CYCLES = 32'h0000_0010
) (
  input wire logic clk,
  input wire logic rst_b,
  output logic blink_phase
);

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic phase_reg;
  logic phase_next;

  // one shared phase keeps every blinking lamp in step
  always_comb begin
    cnt_next = cnt_reg + 32'h1;
    phase_next = phase_reg;
    if (cnt_reg >= HALF_CYCLES - 32'h1) begin
      cnt_next = 32'h0;
      phase_next = ~phase_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_reg <= 32'h0;
      phase_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      phase_reg <= phase_next;
    end
  end

  assign blink_phase = phase_reg;

endmodule : rslc_blink_div

// ### verif/rslc_lamp_model.sv
// rslc_lamp_model: front-panel lamp observer that counts lamp transitions.
// assumes lamps settle on clk; clr restarts every count.
`timescale 1ns/1ns
module rslc_lamp_model (
  input wire logic clk,
  input wire logic clr,
  input wire logic [4:0] lamps,
  output logic [4:0][7:0] flips
);
  logic [4:0] last_reg;
  // a steady or dark lamp counts nothing, a blinking one climbs fast
  always @(posedge clk) begin
    last_reg <= lamps;
    for (int i = 0; i < 5; i++) begin
      if (clr) flips[i] <= 8'h00;
      else if (lamps[i] !== last_reg[i]) flips[i] <= flips[i] + 8'h01;
    end
  end
endmodule : rslc_lamp_model

// ### verif/rslc_lamp_ctrl_bench.sv
// rslc_lamp_ctrl_bench: self-checking bench of the status lamp controller.
// assumes short counts (shutdown 50, blink half period 4) and blink when unlinked.
`timescale 1ns/1ns
module rslc_lamp_ctrl_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  rslc_pkg::rslc_apb_req_type req = '0;
  rslc_pkg::rslc_status_type st = '0;
  logic batt = 1'b0;
  logic wl = 1'b0;
  logic clr = 1'b0;
  logic pready, pslverr, force_2d, auto_shutdown, irq, err;
  logic [31:0] prdata, rd;
  logic [4:0] lamps;
  logic [4:0][7:0] flips;
  int n_fail = 0;
  int checked = 0;
  // 125 MHz
  always #4 clk = ~clk;
  rslc_lamp_ctrl #(.LOW_BATT_CYCLES(40'h32), .BLINK_HALF_CYCLES(32'h4),
    .WL_BLINK_IDLE(1'b1)) u_dut (
    .clk(clk), .rst_b(rst_b), .apb_req(req), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .status(st), .batt_low_pin(batt), .wireless_conn_pin(wl),
    .power_indicator(lamps[0]), .sat_lock_indicator(lamps[1]),
    .correction_lock_indicator_position_indicator(lamps[2]), .correction_lock_indicator(lamps[3]),
    .wireless_indicator(lamps[4]), .force_2d(force_2d), .auto_shutdown(auto_shutdown),
    .irq(irq));
  rslc_lamp_model u_lamps (.clk(clk), .clr(clr), .lamps(lamps), .flips(flips));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  // apb master; waits for pready with no cycle budget, the watchdog ends a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req <= '0;
  endtask : apb
  // kind 0 off, 1 steady on, 2 blinking; 40 cycles hold about ten blink flips
  task automatic watch(input int idx, input logic [1:0] kind, input string what);
    repeat (4) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (40) @(posedge clk);
    // judge off the edge, then hand back on a rising edge for the next drive
    @(negedge clk);
    chk((flips[idx] >= 8'h08) ? 32'h2 : {31'h0, lamps[idx]}, {30'h0, kind}, what);
    @(posedge clk);
  endtask : watch
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({27'h0, lamps}, 32'h0, "lamps in reset");
    @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, rslc_pkg::ADDR_RESIDUAL_LIMIT_COMMAND, 32'h0);
    chk(rd, 32'h64, "residual default");
    apb(1'b0, rslc_pkg::ADDR_PRECISION_THRESHOLD_COMMAND, 32'h0);
    chk(rd, 32'h69, "precision default");
    apb(1'b0, 8'h14, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
    watch(0, 2'h1, "power steady");
  endtask : t_reset
  task automatic t_sat();
    watch(1, 2'h2, "no lock blinks");
    apb(1'b1, rslc_pkg::ADDR_IRQ_MASK, 32'h4);
    st.sat_lock <= 1'b1;
    watch(1, 2'h1, "lock steady");
    @(negedge clk);
    chk({31'h0, irq}, 32'h1, "lock irq");
    apb(1'b1, rslc_pkg::ADDR_IRQ_STAT, 32'h4);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    @(posedge clk);
  endtask : t_sat
  task automatic t_pos();
    st.correction_lock_indicator_solution <= 1'b1;
    st.fix_3d <= 1'b1;
    st.residual_dm <= 16'h0063;
    st.pdop_x10 <= 16'h0069;
    watch(2, 2'h1, "dgps steady");
    chk({31'h0, force_2d}, 32'h0, "pdop at limit");
    st.residual_dm <= 16'h0064;
    watch(2, 2'h2, "residual blink");
    st.residual_dm <= 16'h0063;
    st.pdop_x10 <= 16'h006A;
    watch(2, 2'h2, "pdop blink");
    chk({31'h0, force_2d}, 32'h1, "force 2d");
    apb(1'b1, rslc_pkg::ADDR_PRECISION_THRESHOLD_COMMAND, 32'h6A);
    apb(1'b1, rslc_pkg::ADDR_RESIDUAL_LIMIT_COMMAND, 32'hC8);
    st.residual_dm <= 16'h00C7;
    watch(2, 2'h1, "new limits");
    st.correction_lock_indicator_solution <= 1'b0;
    watch(2, 2'h0, "no differential");
  endtask : t_pos
  task automatic t_corr();
    st.corr_locked <= 1'b1;
    st.ber <= 16'h0095;
    watch(3, 2'h1, "good lock");
    st.ber <= 16'h0096;
    watch(3, 2'h2, "marginal lock");
    st.ber <= 16'h01F4;
    watch(3, 2'h0, "no lock value");
    st.ext_corr_ok <= 1'b1;
    watch(3, 2'h1, "external data");
    wl <= 1'b1;
    watch(4, 2'h1, "link up");
    wl <= 1'b0;
    watch(4, 2'h2, "link down");
  endtask : t_corr
  // shutdown must not come before the 50-cycle countdown, but soon after it
  task automatic t_batt();
    batt <= 1'b1;
    watch(0, 2'h2, "low battery");
    // sync 2 edges, entry 1 edge, 50 edges of countdown: shutdown lands 53 edges in
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk({31'h0, auto_shutdown}, 32'h0, "early shutdown");
    @(negedge clk);
    chk({31'h0, auto_shutdown}, 32'h1, "shutdown");
    @(negedge clk);
    chk({27'h0, lamps}, 32'h0, "dark panel");
    apb(1'b0, rslc_pkg::ADDR_IRQ_STAT, 32'h0);
    chk({28'h0, rd[3:0]}, 32'hB, "battery and lock lost events");
    apb(1'b0, rslc_pkg::ADDR_LAMP_STATE, 32'h0);
    chk(rd, 32'h0000_0240, "lamp state in shutdown");
  endtask : t_batt
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    t_reset();
    t_sat();
    t_pos();
    t_corr();
    t_batt();
    wrap_up();
  end
  // the run needs about 730 cycles; allow about thirteen times that
  initial begin
    #80000;
    n_fail++;
    wrap_up();
  end
endmodule : rslc_lamp_ctrl_bench
